// [rtl/timer_defs.svh]
// Register offsets, field positions and timing counts of the free-running timer
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH

`define ADDR_W 4
`define DATA_W 8
`define CNT_W 16

`define OFS_FIRST_CTRL 4'h0
`define OFS_SECOND_CTRL 4'h1
`define OFS_STATUS 4'h2
`define OFS_CNT_HI 4'h3
`define OFS_CNT_LO 4'h4
`define OFS_ALT_HI 4'h5
`define OFS_ALT_LO 4'h6
`define OFS_CMP0_HI 4'h7
`define OFS_CMP0_LO 4'h8
`define OFS_CMP1_HI 4'h9
`define OFS_CMP1_LO 4'hA

// First control register fields
`define F1_LEVEL0 0
`define F1_LEVEL1 1
`define F1_FORCE0 2
`define F1_FORCE1 3
`define F1_OVF_IE 5
`define F1_CMP_IE 6

// Second control register fields
`define F2_PIN_EN0 0
`define F2_PIN_EN1 1
`define F2_CLK_LO 2
`define F2_CLK_HI 3
`define F2_EXT_EDGE 4
`define F2_ONE_PULSE 5
`define F2_PWM 6

// Status register fields
`define FS_OVF 0
`define FS_CMP0 1
`define FS_CMP1 2

`define CTRL_RESET 8'h00
`define CNT_RESET 16'h0000
`define CNT_MAX 16'hFFFF
`define CMP_RESET 16'hFFFF

// Internal prescale divisors, in CPU clock cycles per count
`define DIV_A 4'h4
`define DIV_B 4'h2
`define DIV_C 4'h8
`define DIV_W 4

`endif

// [rtl/timer_pkg.sv]
// Types shared by the free-running timer modules
package timer_pkg;
	typedef enum logic [1:0] {
		SRC_DIV4,
		SRC_DIV2,
		SRC_DIV8,
		SRC_EXT
	} clk_src_e;
endpackage

// [rtl/ext_edge_sync.sv]
// Two-flop synchroniser and edge selector for the external count clock
`timescale 1ns/10ps
module ext_edge_sync (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_sync_b,
	// Pin and edge choice
	input wire logic pin_in,
	input wire logic rising_sel,
	// One-cycle pulse per selected edge
	output logic edge_pulse
);
	logic meta_q;
	logic sync_q;
	logic prev_q;
	logic [2:0] fill_q;

	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			prev_q <= 1'b0;
		end else begin
			meta_q <= pin_in;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	// Edges are ignored until the pipe holds real pin samples, whatever the pin idles at
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			fill_q <= 3'h0;
		end else begin
			fill_q <= {fill_q[1:0], 1'b1};
		end
	end

	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			edge_pulse <= 1'b0;
		end else begin
			edge_pulse <= fill_q[2] && (rising_sel ? (sync_q & ~prev_q) : (~sync_q & prev_q));
		end
	end
endmodule

// [rtl/compare_channel.sv]
// One output compare channel: value, inhibit, match flag and pin
`timescale 1ns/10ps
`include "timer_defs.svh"
module compare_channel #(
	parameter int CNT_W = `CNT_W
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_sync_b,
	// Register writes
	input wire logic [7:0] wdata,
	input wire logic hi_wr,
	input wire logic lo_wr,
	// Control
	input wire logic [CNT_W-1:0] count,
	input wire logic level,
	input wire logic pin_en,
	input wire logic force_pulse,
	input wire logic flag_clr,
	// State
	output logic [CNT_W-1:0] value_q,
	output logic flag_q,
	output logic pin_q,
	output logic pin_oe_b_q
);
	logic inhibit_q;
	logic match;

	assign match = (count == value_q) && !inhibit_q;

	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			value_q <= `CMP_RESET;
			inhibit_q <= 1'b0;
		end else if (hi_wr) begin
			value_q[CNT_W-1:8] <= wdata;
			inhibit_q <= 1'b1;
		end else if (lo_wr) begin
			value_q[7:0] <= wdata;
			inhibit_q <= 1'b0;
		end
	end

	// A match in the clearing cycle keeps the flag set
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			flag_q <= 1'b0;
		end else if (match) begin
			flag_q <= 1'b1;
		end else if (flag_clr) begin
			flag_q <= 1'b0;
		end
	end

	// Pin only reaches the level when enabled; otherwise it is left to the port
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			pin_q <= 1'b0;
			pin_oe_b_q <= 1'b1;
		end else begin
			pin_oe_b_q <= ~pin_en;
			if (pin_en && (match || force_pulse)) begin
				pin_q <= level;
			end
		end
	end

	chk_inhibit_blocks: assert property (@(posedge clk) disable iff (!rst_sync_b)
		inhibit_q && !flag_q && !lo_wr |=> !flag_q)
		else $error("compare flag set while compare is inhibited");
	chk_force_no_flag: assert property (@(posedge clk) disable iff (!rst_sync_b)
		force_pulse && !match && !flag_q |=> !flag_q)
		else $error("forced output set the compare flag");
	chk_pin_disabled: assert property (@(posedge clk) disable iff (!rst_sync_b)
		!pin_en && match |=> $stable(pin_q) && flag_q)
		else $error("disabled pin changed on match or flag missed");
endmodule

// [rtl/free_running_timer_compare.sv]
// Free-running 16-bit timer with buffered reads, overflow and two compare channels
// Notes on behaviour
// - High byte read first latches low byte
// - Latched low byte held until low read
// - Unlatched low read returns live count
// - Wrap from max to zero sets overflow
// - Interrupt needs enable and clear global mask
// - Overflow clears: status read, then low access
// - Alternate low register never clears overflow
// - Halt freezes counter; wait has no effect
// - Both clock-select bits pick external clock
// - Edge-select bit picks active pin edge
// - External edges synchronised to CPU clock
// - High compare write inhibits until low
// - Disabled pin ignores match, flag still sets
// - Flag and pin set on equality
// - Force copies level, never sets flag
// - Force ignored in one-pulse or PWM
// - No input capture; compare channels only
//
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`include "timer_defs.svh"
module free_running_timer_compare
	import timer_pkg::*;
#(
	parameter int CNT_W = `CNT_W,
	parameter int NCH = 2
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// Register port
	input wire logic [`ADDR_W-1:0] addr,
	input wire logic [`DATA_W-1:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [`DATA_W-1:0] rdata_q,
	// System state
	input wire logic irq_mask,
	input wire logic halt_mode,
	// External clock pin
	input wire logic ext_clock_pin,
	// Compare pins
	output logic [NCH-1:0] compare_output_pin_q,
	output logic [NCH-1:0] compare_output_oe_b_q,
	// Interrupt request
	output logic irq_q
);
	logic rst_meta_q;
	logic rst_sync_b;
	logic [7:0] first_control_reg_q;
	logic [7:0] second_control_reg_q;
	logic [CNT_W-1:0] cnt_q;
	logic [7:0] lo_latch_q;
	logic latched_q;
	logic overflow_flag_q;
	logic ovf_armed_q;
	logic cmp_armed_q;
	logic [`DIV_W-1:0] div_q;
	logic [`DIV_W-1:0] div_lim;
	logic div_tick;
	logic ext_tick;
	logic tick;
	logic wrap;
	clk_src_e src;
	logic [NCH-1:0] lvl;
	logic [NCH-1:0] pin_en;
	logic [NCH-1:0] force_pulse;
	logic [NCH-1:0] cmp_hi_wr;
	logic [NCH-1:0] cmp_lo_wr;
	logic [NCH-1:0] cmp_flag;
	logic [NCH-1:0] cmp_flag_clr;
	logic [CNT_W-1:0] cmp_val [NCH];
	logic [NCH-1:0] cmp_pin;
	logic [NCH-1:0] cmp_oe_b;
	logic rd_hi;
	logic rd_lo_main;
	logic rd_lo_alt;
	logic acc_lo_main;
	logic rd_status;
	logic modes_block_force;
	logic irq_d;
	logic [7:0] rd_d;

	// Reset release through two flops; assertion stays asynchronous
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta_q <= 1'b0;
			rst_sync_b <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_b <= rst_meta_q;
		end
	end

	assign src = clk_src_e'(second_control_reg_q[`F2_CLK_HI:`F2_CLK_LO]);
	// A level written together with a force bit is the one that reaches the pin
	always_comb begin
		lvl = first_control_reg_q[`F1_LEVEL1:`F1_LEVEL0];
		if (wr_en && addr == `OFS_FIRST_CTRL) begin
			lvl = wdata[`F1_LEVEL1:`F1_LEVEL0];
		end
	end
	assign pin_en = second_control_reg_q[`F2_PIN_EN1:`F2_PIN_EN0];
	assign modes_block_force = second_control_reg_q[`F2_ONE_PULSE]
		| second_control_reg_q[`F2_PWM];

	assign rd_hi = rd_en && (addr == `OFS_CNT_HI || addr == `OFS_ALT_HI);
	assign rd_lo_main = rd_en && (addr == `OFS_CNT_LO);
	assign rd_lo_alt = rd_en && (addr == `OFS_ALT_LO);
	assign acc_lo_main = (rd_en || wr_en) && (addr == `OFS_CNT_LO);
	assign rd_status = rd_en && (addr == `OFS_STATUS);

	// Control registers; force bits are write-one pulses and never stored
	always_ff @(posedge sys_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			first_control_reg_q <= `CTRL_RESET;
		end else if (wr_en && addr == `OFS_FIRST_CTRL) begin
			first_control_reg_q <= wdata & ~8'h0C;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			second_control_reg_q <= `CTRL_RESET;
		end else if (wr_en && addr == `OFS_SECOND_CTRL) begin
			second_control_reg_q <= wdata;
		end
	end

	always_comb begin
		force_pulse = '0;
		if (wr_en && addr == `OFS_FIRST_CTRL && !modes_block_force) begin
			force_pulse = wdata[`F1_FORCE1:`F1_FORCE0];
		end
	end

	// Internal prescaler: one-cycle enable every div_lim CPU cycles
	always_comb begin
		case (src)
			SRC_DIV4: div_lim = `DIV_A;
			SRC_DIV2: div_lim = `DIV_B;
			SRC_DIV8: div_lim = `DIV_C;
			default: div_lim = `DIV_A;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			div_q <= '0;
		end else if (halt_mode || div_tick) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + 4'h1;
		end
	end

	assign div_tick = (div_q == div_lim - 4'h1) && !halt_mode;

	// Pin edges are resynchronised, so the source must stay under a quarter of the rate
	ext_edge_sync u_ext_sync (
		.clk(sys_clk),
		.rst_sync_b(rst_sync_b),
		.pin_in(ext_clock_pin),
		.rising_sel(second_control_reg_q[`F2_EXT_EDGE]),
		.edge_pulse(ext_tick)
	);

	assign tick = !halt_mode && ((src == SRC_EXT) ? ext_tick : div_tick);
	assign wrap = tick && (cnt_q == `CNT_MAX);

	// Reads never stall the count; halt only holds it
	always_ff @(posedge sys_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			cnt_q <= `CNT_RESET;
		end else if (tick) begin
			cnt_q <= cnt_q + 16'h0001;
		end
	end

	// Buffered two-byte read
	always_ff @(posedge sys_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			lo_latch_q <= 8'h00;
			latched_q <= 1'b0;
		end else if (rd_lo_main || rd_lo_alt) begin
			latched_q <= 1'b0;
		end else if (rd_hi && !latched_q) begin
			lo_latch_q <= cnt_q[7:0];
			latched_q <= 1'b1;
		end
	end

	// Overflow flag: a wrap in the clearing cycle wins
	always_ff @(posedge sys_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			overflow_flag_q <= 1'b0;
			ovf_armed_q <= 1'b0;
		end else begin
			if (wrap) begin
				overflow_flag_q <= 1'b1;
			end else if (ovf_armed_q && acc_lo_main) begin
				overflow_flag_q <= 1'b0;
			end
			if (rd_status && overflow_flag_q) begin
				ovf_armed_q <= 1'b1;
			end else if (acc_lo_main || !overflow_flag_q) begin
				ovf_armed_q <= 1'b0;
			end
		end
	end

	// Compare flags clear by a status read with a flag set, then a low compare write
	always_ff @(posedge sys_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			cmp_armed_q <= 1'b0;
		end else if (rd_status && |cmp_flag) begin
			cmp_armed_q <= 1'b1;
		end else if (|cmp_lo_wr) begin
			cmp_armed_q <= 1'b0;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < NCH; gi++) begin : g_ch
			assign cmp_hi_wr[gi] = wr_en && (addr == `OFS_CMP0_HI + 4'(2 * gi));
			assign cmp_lo_wr[gi] = wr_en && (addr == `OFS_CMP0_LO + 4'(2 * gi));
			assign cmp_flag_clr[gi] = cmp_armed_q && cmp_lo_wr[gi];
			compare_channel #(
				.CNT_W(CNT_W)
			) u_ch (
				.clk(sys_clk),
				.rst_sync_b(rst_sync_b),
				.wdata(wdata),
				.hi_wr(cmp_hi_wr[gi]),
				.lo_wr(cmp_lo_wr[gi]),
				.count(cnt_q),
				.level(lvl[gi]),
				.pin_en(pin_en[gi]),
				.force_pulse(force_pulse[gi]),
				.flag_clr(cmp_flag_clr[gi]),
				.value_q(cmp_val[gi]),
				.flag_q(cmp_flag[gi]),
				.pin_q(cmp_pin[gi]),
				.pin_oe_b_q(cmp_oe_b[gi])
			);
		end
	endgenerate

	always_ff @(posedge sys_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			compare_output_pin_q <= '0;
			compare_output_oe_b_q <= '1;
		end else begin
			compare_output_pin_q <= cmp_pin;
			compare_output_oe_b_q <= cmp_oe_b;
		end
	end

	// Pending requests simply wait in the flags until the mask opens
	assign irq_d = !irq_mask && ((overflow_flag_q && first_control_reg_q[`F1_OVF_IE])
		|| (|cmp_flag && first_control_reg_q[`F1_CMP_IE]));

	always_ff @(posedge sys_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= irq_d;
		end
	end

	// Read mux; unmapped offsets read zero
	always_comb begin
		rd_d = 8'h00;
		case (addr)
			`OFS_FIRST_CTRL: rd_d = first_control_reg_q;
			`OFS_SECOND_CTRL: rd_d = second_control_reg_q;
			`OFS_STATUS: rd_d = {5'h00, cmp_flag[1], cmp_flag[0], overflow_flag_q};
			`OFS_CNT_HI, `OFS_ALT_HI: rd_d = cnt_q[15:8];
			`OFS_CNT_LO, `OFS_ALT_LO: rd_d = latched_q ? lo_latch_q : cnt_q[7:0];
			`OFS_CMP0_HI: rd_d = cmp_val[0][15:8];
			`OFS_CMP0_LO: rd_d = cmp_val[0][7:0];
			`OFS_CMP1_HI: rd_d = cmp_val[1][15:8];
			`OFS_CMP1_LO: rd_d = cmp_val[1][7:0];
			default: rd_d = 8'h00;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			rdata_q <= 8'h00;
		end else if (rd_en) begin
			rdata_q <= rd_d;
		end else begin
			rdata_q <= 8'h00;
		end
	end

	chk_latch_hold: assert property (@(posedge sys_clk) disable iff (!rst_sync_b)
		latched_q && rd_hi |=> latched_q && $stable(lo_latch_q))
		else $error("latched low byte changed before low read");
	chk_latch_take: assert property (@(posedge sys_clk) disable iff (!rst_sync_b)
		rd_hi && !latched_q |=> lo_latch_q == $past(cnt_q[7:0]))
		else $error("high read did not latch the low byte");
	chk_live_low: assert property (@(posedge sys_clk) disable iff (!rst_sync_b)
		(rd_lo_main || rd_lo_alt) && !latched_q |=> rdata_q == $past(cnt_q[7:0]))
		else $error("unlatched low read did not return live count");
	chk_ovf_set: assert property (@(posedge sys_clk) disable iff (!rst_sync_b)
		tick && cnt_q == 16'hFFFF |=> overflow_flag_q && cnt_q == 16'h0000)
		else $error("wrap did not set overflow");
	chk_ovf_alt_keep: assert property (@(posedge sys_clk) disable iff (!rst_sync_b)
		overflow_flag_q && !acc_lo_main ##1 !acc_lo_main |-> overflow_flag_q)
		else $error("overflow cleared without main low access");
	chk_ovf_clear: assert property (@(posedge sys_clk) disable iff (!rst_sync_b)
		rd_status && overflow_flag_q ##1 acc_lo_main && !wrap |=> !overflow_flag_q)
		else $error("two-step sequence failed to clear overflow");
	chk_irq_gate: assert property (@(posedge sys_clk) disable iff (!rst_sync_b)
		overflow_flag_q && first_control_reg_q[5] && !irq_mask |=> irq_q)
		else $error("pending overflow not requested");
	chk_irq_masked: assert property (@(posedge sys_clk) disable iff (!rst_sync_b)
		irq_mask |=> !irq_q)
		else $error("request issued while masked");
	chk_halt_freeze: assert property (@(posedge sys_clk) disable iff (!rst_sync_b)
		halt_mode [*3] |=> $stable(cnt_q))
		else $error("counter moved in halt");
	chk_ext_count: assert property (@(posedge sys_clk) disable iff (!rst_sync_b)
		src == SRC_EXT && ext_tick && !halt_mode |=> cnt_q == $past(cnt_q) + 16'h0001)
		else $error("external edge did not advance counter");
	chk_force_block: assert property (@(posedge sys_clk) disable iff (!rst_sync_b)
		modes_block_force |-> force_pulse == '0)
		else $error("force honoured in pulse or pwm mode");
	chk_force_level: assert property (@(posedge sys_clk) disable iff (!rst_sync_b)
		force_pulse[0] && pin_en[0] |-> ##2 compare_output_pin_q[0] == $past(lvl[0], 2))
		else $error("forced pin did not take the level bit");
	chk_alt_no_clear: assert property (@(posedge sys_clk) disable iff (!rst_sync_b)
		rd_lo_alt && overflow_flag_q |=> overflow_flag_q)
		else $error("alternate low read cleared overflow");

	cov_ovf_irq: cover property (@(posedge sys_clk) disable iff (!rst_sync_b)
		wrap ##[1:3] irq_q);
	cov_ext_tick: cover property (@(posedge sys_clk) disable iff (!rst_sync_b)
		src == SRC_EXT && ext_tick);
	cov_cmp_match: cover property (@(posedge sys_clk) disable iff (!rst_sync_b)
		$rose(cmp_flag[0]));
	cov_two_byte: cover property (@(posedge sys_clk) disable iff (!rst_sync_b)
		rd_hi ##1 rd_lo_main);
endmodule

// [test/ext_clock_source.sv]
// External count clock source that only moves when the bench asks it to
`timescale 1ns/10ps
module ext_clock_source (
	// Clock
	input wire logic sys_clk,
	// Count clock pin
	output logic ext_clock_pin
);
	initial begin
		ext_clock_pin = 1'b0;
	end

	// Edges four CPU cycles apart: the fastest spacing the timer must accept
	task automatic toggle(input int n);
		for (int i = 0; i < n; i++) begin
			repeat (4) @(posedge sys_clk);
			ext_clock_pin <= ~ext_clock_pin;
		end
	endtask
endmodule

// [test/free_running_timer_compare_tb.sv]
// Register-level testbench of the free-running timer with two compare channels
`timescale 1ns/10ps
`include "timer_defs.svh"
`define CHECK_EQ(got, exp) begin \
	cmp_count++; \
	if ((got) !== (exp)) begin \
		errors++; \
		$display("CHECK FAILED t=%0t got %h exp %h", $time, (got), (exp)); \
	end \
end
module free_running_timer_compare_tb;
	logic sys_clk;
	logic rst_b;
	logic [`ADDR_W-1:0] addr;
	logic [`DATA_W-1:0] wdata;
	logic wr_en;
	logic rd_en;
	logic [`DATA_W-1:0] rdata_q;
	logic irq_mask;
	logic halt_mode;
	logic ext_clock_pin;
	logic [1:0] cmp_pin;
	logic [1:0] cmp_oe_b;
	logic irq_q;
	logic [7:0] d;
	logic [15:0] c;
	logic [15:0] n1;
	logic [15:0] n2;
	int errors;
	int cmp_count;

	free_running_timer_compare dut (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.addr(addr),
		.wdata(wdata),
		.wr_en(wr_en),
		.rd_en(rd_en),
		.rdata_q(rdata_q),
		.irq_mask(irq_mask),
		.halt_mode(halt_mode),
		.ext_clock_pin(ext_clock_pin),
		.compare_output_pin_q(cmp_pin),
		.compare_output_oe_b_q(cmp_oe_b),
		.irq_q(irq_q)
	);

	ext_clock_source u_src (
		.sys_clk(sys_clk),
		.ext_clock_pin(ext_clock_pin)
	);

	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	task automatic wrap_up();
		$display("Mismatches %0d, comparisons %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge sys_clk);
		addr <= a;
		wdata <= v;
		wr_en <= 1'b1;
		@(posedge sys_clk);
		wr_en <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		@(posedge sys_clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge sys_clk);
		rd_en <= 1'b0;
		#1;
		v = rdata_q;
	endtask

	task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
		rd(a, d);
		`CHECK_EQ(d, exp)
	endtask

	// Counter moves only after the pin edge has crossed the synchroniser
	task automatic tick(input int n);
		u_src.toggle(n);
		cyc(12);
	endtask

	// The overflow wait at the fastest prescale takes about 131k cycles
	initial begin
		repeat (200000) @(posedge sys_clk);
		errors++;
		wrap_up();
	end

	initial begin
		rst_b = 1'b0;
		addr = '0;
		wdata = '0;
		wr_en = 1'b0;
		rd_en = 1'b0;
		irq_mask = 1'b1;
		halt_mode = 1'b1;
		errors = 0;
		cmp_count = 0;
		d = '0;
		repeat (3) @(posedge sys_clk);
		rst_b <= 1'b1;
		cyc(4);
		`CHECK_EQ(cmp_pin, 2'b00)
		`CHECK_EQ(cmp_oe_b, 2'b11)
		rdc(`OFS_FIRST_CTRL, `CTRL_RESET);
		rdc(`OFS_SECOND_CTRL, `CTRL_RESET);
		rdc(`OFS_STATUS, 8'h00);
		rdc(4'hF, 8'h00);
		rdc(`OFS_CNT_LO, 8'h00);
		rdc(`OFS_CNT_HI, 8'h00);
		@(posedge sys_clk);
		halt_mode <= 1'b0;
		repeat (40) @(posedge sys_clk);
		halt_mode <= 1'b1;
		rdc(`OFS_CNT_HI, 8'h00);
		rdc(`OFS_CNT_LO, 8'h00);
		rdc(`OFS_CNT_LO, 8'h0A);
		@(posedge sys_clk);
		halt_mode <= 1'b0;
		wr(`OFS_FIRST_CTRL, 8'h20);
		wr(`OFS_SECOND_CTRL, 8'h04);
		for (int i = 0; i < 9000 && d[0] !== 1'b1; i++) begin
			cyc(14);
			rd(`OFS_STATUS, d);
		end
		`CHECK_EQ(d[0], 1'b1)
		`CHECK_EQ(irq_q, 1'b0)
		@(posedge sys_clk);
		irq_mask <= 1'b0;
		cyc(3);
		`CHECK_EQ(irq_q, 1'b1)
		rd(`OFS_ALT_LO, d);
		rd(`OFS_STATUS, d);
		`CHECK_EQ(d[0], 1'b1)
		rd(`OFS_CNT_LO, d);
		rd(`OFS_STATUS, d);
		`CHECK_EQ(d[0], 1'b0)
		cyc(2);
		`CHECK_EQ(irq_q, 1'b0)
		wr(`OFS_SECOND_CTRL, 8'h1C);
		cyc(8);
		rd(`OFS_CNT_HI, d);
		c[15:8] = d;
		rd(`OFS_CNT_LO, d);
		c[7:0] = d;
		tick(1);
		c = c + 16'h0001;
		rdc(`OFS_CNT_LO, c[7:0]);
		tick(1);
		rdc(`OFS_CNT_LO, c[7:0]);
		wr(`OFS_SECOND_CTRL, 8'h0C);
		tick(1);
		rdc(`OFS_CNT_LO, c[7:0]);
		tick(1);
		c = c + 16'h0001;
		rdc(`OFS_CNT_LO, c[7:0]);
		n1 = c + 16'h0001;
		n2 = c + 16'h0002;
		wr(`OFS_FIRST_CTRL, 8'h21);
		wr(`OFS_SECOND_CTRL, 8'h1D);
		rd(`OFS_STATUS, d);
		wr(`OFS_CMP0_HI, n1[15:8]);
		wr(`OFS_CMP0_LO, n1[7:0]);
		rd(`OFS_STATUS, d);
		wr(`OFS_CMP1_HI, n2[15:8]);
		wr(`OFS_CMP1_LO, n2[7:0]);
		wr(`OFS_CMP1_HI, n2[15:8]);
		rd(`OFS_STATUS, d);
		`CHECK_EQ(d[2:0], 3'b000)
		tick(2);
		rd(`OFS_STATUS, d);
		`CHECK_EQ(d[2:0], 3'b010)
		`CHECK_EQ(cmp_pin, 2'b01)
		`CHECK_EQ(cmp_oe_b, 2'b10)
		tick(2);
		rd(`OFS_STATUS, d);
		`CHECK_EQ(d[2], 1'b0)
		wr(`OFS_CMP1_LO, n2[7:0]);
		cyc(3);
		rd(`OFS_STATUS, d);
		`CHECK_EQ(d[2:1], 2'b11)
		`CHECK_EQ(cmp_pin, 2'b01)
		wr(`OFS_FIRST_CTRL, 8'h41);
		cyc(3);
		`CHECK_EQ(irq_q, 1'b1)
		// Status read then low compare write clears channel 0's flag
		rd(`OFS_STATUS, d);
		wr(`OFS_CMP0_LO, n1[7:0] ^ 8'h80);
		rd(`OFS_STATUS, d);
		`CHECK_EQ(d[1], 1'b0)
		wr(`OFS_FIRST_CTRL, 8'h44);
		cyc(3);
		`CHECK_EQ(cmp_pin[0], 1'b0)
		rd(`OFS_STATUS, d);
		`CHECK_EQ(d[1], 1'b0)
		wr(`OFS_FIRST_CTRL, 8'h45);
		cyc(3);
		`CHECK_EQ(cmp_pin[0], 1'b1)
		rdc(`OFS_FIRST_CTRL, 8'h41);
		for (int i = 0; i < 2; i++) begin
			wr(`OFS_SECOND_CTRL, 8'h1D | (8'h20 << i));
			wr(`OFS_FIRST_CTRL, 8'h44);
			cyc(3);
			`CHECK_EQ(cmp_pin[0], 1'b1)
		end
		@(posedge sys_clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rst_b <= 1'b1;
		cyc(4);
		`CHECK_EQ(cmp_oe_b, 2'b11)
		rdc(`OFS_CNT_HI, 8'h00);
		rdc(`OFS_CNT_LO, 8'h00);
		wrap_up();
	end
endmodule
